//--- rcr_pkg.sv
`default_nettype none
package rcr_pkg;
   // register byte addresses
   localparam logic [31:0] RCR_ADDR_MAP_CTRL   = 32'hFFFF0220;
   localparam logic [31:0] RCR_ADDR_CAUSE      = 32'hFFFF0230;
   localparam logic [31:0] RCR_ADDR_CAUSE_CLR  = 32'hFFFF0234;
   localparam logic [31:0] RCR_ADDR_KEY_FIRST  = 32'hFFFF0248;
   localparam logic [31:0] RCR_ADDR_RET_CFG    = 32'hFFFF024C;
   localparam logic [31:0] RCR_ADDR_KEY_SECOND = 32'hFFFF0250;
   localparam logic [31:0] RCR_ADDR_IRQ_STAT   = 32'hFFFF0260;
   localparam logic [31:0] RCR_ADDR_IRQ_MASK   = 32'hFFFF0264;

   // unlock keys, reset values and the retention write mask
   localparam logic [7:0]  RCR_KEY_FIRST       = 8'h76;
   localparam logic [7:0]  RCR_KEY_SECOND      = 8'hB1;
   localparam logic [2:0]  RCR_CAUSE_RST       = 3'h1;
   localparam logic [7:0]  RCR_CFG_RST         = 8'h00;
   localparam logic [7:0]  RCR_CFG_WMASK       = 8'h05;
   localparam logic [4:0]  RCR_IRQ_RST         = 5'h00;

   // memory map control fields
   localparam int          RCR_MAP_SRAM_BIT    = 0;
   localparam int          RCR_SRAM_SMALL_BIT  = 3;
   localparam int          RCR_FLASH_SMALL_BIT = 4;
   localparam logic [1:0]  RCR_DBG_DEBUG       = 2'h0;
   localparam logic [1:0]  RCR_DBG_GPIO        = 2'h2;

   // reset cause fields
   localparam int          RCR_CAUSE_POR       = 0;
   localparam int          RCR_CAUSE_WDT       = 1;
   localparam int          RCR_CAUSE_SW        = 2;

   // retention fields
   localparam int          RCR_CFG_GPIO        = 0;
   localparam int          RCR_CFG_DAC         = 2;

   // interrupt event positions
   localparam int          RCR_EV_SW           = 0;
   localparam int          RCR_EV_WDT          = 1;
   localparam int          RCR_EV_EXT          = 2;
   localparam int          RCR_EV_COMMIT       = 3;
   localparam int          RCR_EV_ABORT        = 4;

   // key sequence states
   typedef enum logic [1:0] {
      RCR_KEY_IDLE  = 2'b00,
      RCR_KEY_ARMED = 2'b01,
      RCR_KEY_HELD  = 2'b10
   } rcr_key_state_t;
endpackage : rcr_pkg
`default_nettype wire

//--- rcr_reset_remap_ctrl.sv
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module rcr_reset_remap_ctrl
   import rcr_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // register port
   input  wire logic [31:0] addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   // reset events of the chip
   input  wire logic        ext_reset_evt,
   input  wire logic        wdt_reset_evt,
   output logic             sw_reset_req,
   // straps
   input  wire logic        boot_strap_pin,
   input  wire logic        flash_small,
   input  wire logic        sram_small,
   // memory map and shared pins
   output logic             sram_at_zero,
   output logic             debug_port_en,
   // peripheral retention
   output logic             gpio_retain,
   output logic             dac_retain,
   output logic             gpio_restore,
   output logic             dac_restore,
   // interrupt
   output logic             irq
);

   // state
   logic [31:0]    rdata_r;
   logic           sw_fire_r;
   logic [2:0]     cause_r;
   logic [2:0]     cause_nxt;
   logic           map_sram_r;
   logic           strap_r;
   logic           load_pend_r;
   logic [1:0]     dbg_sel_r;
   logic [1:0]     dbg_sel_nxt;
   logic           dbg_en_r;
   rcr_key_state_t key_r;
   rcr_key_state_t key_nxt;
   logic [7:0]     cfg_hold_r;
   logic [7:0]     cfg_r;
   logic           commit;
   logic           abort;
   logic           gpio_rest_r;
   logic           dac_rest_r;
   logic [4:0]     stat_r;
   logic [4:0]     stat_nxt;
   logic [4:0]     mask_r;
   logic           irq_r;

   // address decode
   wire sel_map  = (addr == RCR_ADDR_MAP_CTRL);
   wire sel_cau  = (addr == RCR_ADDR_CAUSE);
   wire sel_clr  = (addr == RCR_ADDR_CAUSE_CLR);
   wire sel_key1 = (addr == RCR_ADDR_KEY_FIRST);
   wire sel_cfg  = (addr == RCR_ADDR_RET_CFG);
   wire sel_key2 = (addr == RCR_ADDR_KEY_SECOND);
   wire sel_stat = (addr == RCR_ADDR_IRQ_STAT);
   wire sel_mask = (addr == RCR_ADDR_IRQ_MASK);
   wire sel_hit  = sel_map | sel_cau | sel_clr | sel_key1 | sel_cfg | sel_key2 | sel_stat | sel_mask;

   // write and read strobes per register
   wire wr_map   = wr & sel_map;
   wire wr_cau   = wr & sel_cau;
   wire wr_clr   = wr & sel_clr;
   wire wr_key1  = wr & sel_key1;
   wire wr_cfg   = wr & sel_cfg;
   wire wr_key2  = wr & sel_key2;
   wire wr_mask  = wr & sel_mask;
   wire wr_hit   = wr & sel_hit;
   wire rd_stat  = rd & sel_stat;
   wire key1_ok  = wr_key1 & (wdata[7:0] == RCR_KEY_FIRST);
   wire key2_ok  = wr_key2 & (wdata[7:0] == RCR_KEY_SECOND);

   // any reset the chip goes through while this block keeps running
   wire sw_force = wr_cau & wdata[RCR_CAUSE_SW];
   wire warm_rst = ext_reset_evt | wdt_reset_evt | sw_fire_r;
   wire soft_rst = wdt_reset_evt | sw_fire_r;

   // cause flags: a set in the same cycle as its clear wins
   wire [2:0] cause_set = {sw_force, wdt_reset_evt, 1'b0};
   wire [2:0] cause_clr = wr_clr ? wdata[2:0] : 3'h0;
   assign cause_nxt = (cause_r & ~cause_clr) | cause_set;

   // debug select follows the strap: low keeps the debug port
   assign dbg_sel_nxt = strap_r ? RCR_DBG_GPIO : RCR_DBG_DEBUG;

   // interrupt events and read-to-clear status
   wire [4:0] events = {abort, commit, ext_reset_evt, wdt_reset_evt, sw_fire_r};
   assign stat_nxt = (rd_stat ? 5'h00 : stat_r) | events;

   // read data selection, unmapped and write-only addresses read zero
   wire [7:0] map_rd = {3'h0, flash_small, sram_small, dbg_sel_r, map_sram_r};
   wire [7:0] rd_mux = sel_map  ? map_rd :
                       sel_cau  ? {5'h00, cause_r} :
                       sel_cfg  ? cfg_r :
                       sel_stat ? {3'h0, stat_r} :
                       sel_mask ? {3'h0, mask_r} : 8'h00;

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_r <= 32'h0000_0000;
      end else begin
         rdata_r <= rd ? {24'h00_0000, rd_mux} : 32'h0000_0000;
      end
   end

   // software reset request is a one-cycle pulse to the chip
   always_ff @(posedge clk) begin
      if (rst) begin
         sw_fire_r <= 1'b0;
      end else begin
         sw_fire_r <= sw_force;
      end
   end

   // cause flags survive warm resets; only power-on loads them
   always_ff @(posedge clk) begin
      if (rst) begin
         cause_r <= RCR_CAUSE_RST;
      end else begin
         cause_r <= cause_nxt;
      end
   end

   // map bit: reset wins over a write in the same cycle
   always_ff @(posedge clk) begin
      if (rst || warm_rst) begin
         map_sram_r <= 1'b0;
      end else if (wr_map) begin
         map_sram_r <= wdata[RCR_MAP_SRAM_BIT];
      end
   end

   // strap caught while any reset is active, loaded one cycle later
   always_ff @(posedge clk) begin
      if (rst || warm_rst) begin
         strap_r <= boot_strap_pin;
      end
   end

   always_ff @(posedge clk) begin
      load_pend_r <= rst | warm_rst;
   end

   // debug select and its pin routing update together
   always_ff @(posedge clk) begin
      if (rst) begin
         dbg_sel_r <= RCR_DBG_DEBUG;
         dbg_en_r  <= 1'b1;
      end else if (load_pend_r) begin
         dbg_sel_r <= dbg_sel_nxt;
         dbg_en_r  <= (dbg_sel_nxt == RCR_DBG_DEBUG);
      end
   end

   // key sequence; any other write to this block except a repeated first key before the value write breaks it
   always_comb begin
      key_nxt = key_r;
      commit  = 1'b0;
      abort   = 1'b0;
      if (wr_hit) begin
         case (key_r)
            RCR_KEY_IDLE: begin
               if (key1_ok) begin
                  key_nxt = RCR_KEY_ARMED;
               end
            end
            RCR_KEY_ARMED: begin
               if (wr_cfg) begin
                  key_nxt = RCR_KEY_HELD;
               end else if (!key1_ok) begin
                  key_nxt = RCR_KEY_IDLE;
                  abort   = 1'b1;
               end
            end
            RCR_KEY_HELD: begin
               key_nxt = RCR_KEY_IDLE;
               if (key2_ok) begin
                  commit = 1'b1;
               end else begin
                  abort = 1'b1;
               end
            end
            default: begin
               key_nxt = RCR_KEY_IDLE;
            end
         endcase
      end
   end

   // a reset of any kind drops a half-done sequence
   always_ff @(posedge clk) begin
      if (rst || warm_rst) begin
         key_r <= RCR_KEY_IDLE;
      end else begin
         key_r <= key_nxt;
      end
   end

   // candidate value waits here until the second key arrives
   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_hold_r <= RCR_CFG_RST;
      end else if (key_r == RCR_KEY_ARMED && wr_cfg) begin
         cfg_hold_r <= wdata[7:0];
      end
   end

   // retention survives watchdog and software resets, not external ones
   always_ff @(posedge clk) begin
      if (rst || ext_reset_evt) begin
         cfg_r <= RCR_CFG_RST;
      end else if (commit) begin
         cfg_r <= cfg_hold_r & RCR_CFG_WMASK;
      end
   end

   // peripheral restore pulses, suppressed on watchdog and software resets where retention is on
   always_ff @(posedge clk) begin
      if (rst) begin
         gpio_rest_r <= 1'b1;
         dac_rest_r  <= 1'b1;
      end else begin
         gpio_rest_r <= ext_reset_evt | (soft_rst & ~cfg_r[RCR_CFG_GPIO]);
         dac_rest_r  <= ext_reset_evt | (soft_rst & ~cfg_r[RCR_CFG_DAC]);
      end
   end

   // interrupt status, mask and level output
   always_ff @(posedge clk) begin
      if (rst) begin
         stat_r <= RCR_IRQ_RST;
         mask_r <= RCR_IRQ_RST;
         irq_r  <= 1'b0;
      end else begin
         stat_r <= stat_nxt;
         if (wr_mask) begin
            mask_r <= wdata[4:0];
         end
         irq_r  <= |(stat_nxt & (wr_mask ? wdata[4:0] : mask_r));
      end
   end

   // outputs straight from flip-flops
   assign rdata         = rdata_r;
   assign sw_reset_req  = sw_fire_r;
   assign sram_at_zero  = map_sram_r;
   assign debug_port_en = dbg_en_r;
   assign gpio_retain   = cfg_r[RCR_CFG_GPIO];
   assign dac_retain    = cfg_r[RCR_CFG_DAC];
   assign gpio_restore  = gpio_rest_r;
   assign dac_restore   = dac_rest_r;
   assign irq           = irq_r;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_remap_write_sets:
   assert property (wr_map && wdata[RCR_MAP_SRAM_BIT] && !warm_rst |=> sram_at_zero)
      else $error("map bit write did not place sram at zero");

   a_remap_reset_clear:
   assert property (warm_rst |=> !sram_at_zero ##1 (sram_at_zero == $past(wr_map && wdata[0] && !warm_rst)))
      else $error("reset did not return flash to address zero");

   a_flash_size_read:
   assert property (rd && sel_map |=> rdata[RCR_FLASH_SMALL_BIT] == $past(flash_small) && rdata[7:5] == 3'h0)
      else $error("flash size bit read wrong");

   a_sram_size_read:
   assert property (rd && sel_map |=> rdata[RCR_SRAM_SMALL_BIT] == $past(sram_small))
      else $error("sram size bit read wrong");

   a_map_bit_read:
   assert property (rd && sel_map |=> rdata[RCR_MAP_SRAM_BIT] == $past(map_sram_r))
      else $error("map bit read wrong");

   a_debug_sel_read:
   assert property (rd && sel_map |=> rdata[2:1] == $past(dbg_sel_r))
      else $error("debug select read wrong");

   a_debug_pin_route:
   assert property (debug_port_en == (dbg_sel_r == RCR_DBG_DEBUG) && dbg_sel_r[0] == 1'b0)
      else $error("debug pin routing disagrees with select");

   a_strap_reload:
   assert property (load_pend_r |=> dbg_sel_r == ($past(strap_r) ? RCR_DBG_GPIO : RCR_DBG_DEBUG))
      else $error("debug select not reloaded from strap");

   a_power_on_flags:
   assert property ($fell(rst) |-> cause_r == RCR_CAUSE_RST)
      else $error("cause flags not 0x01 after power-on");

   a_sw_reset_fire:
   assert property (sw_force |=> sw_reset_req && cause_r[RCR_CAUSE_SW] ##1 !sw_reset_req)
      else $error("software reset not forced and recorded");

   a_wdt_cause_set:
   assert property (wdt_reset_evt |=> cause_r[RCR_CAUSE_WDT])
      else $error("watchdog cause bit not set");

   a_cause_clear_only:
   // a dropped bit must have had its one in the clear write
   assert property ((|($past(cause_r) & ~cause_r)) |->
                    $past(wr_clr) && (($past(cause_r) & ~cause_r & ~$past(wdata[2:0])) == 3'h0))
      else $error("cause bit cleared without clear write");

   a_dac_restore:
   assert property (soft_rst && !ext_reset_evt |=> dac_restore == !$past(cfg_r[RCR_CFG_DAC]))
      else $error("dac restore ignores retention");

   a_gpio_restore:
   assert property (soft_rst && !ext_reset_evt |=> gpio_restore == !$past(cfg_r[RCR_CFG_GPIO]))
      else $error("gpio restore ignores retention");

   a_cfg_commit:
   assert property (key_r == RCR_KEY_HELD && key2_ok && !warm_rst |=> cfg_r == ($past(cfg_hold_r) & RCR_CFG_WMASK))
      else $error("key sequence did not commit retention");

   a_cfg_guarded:
   assert property (cfg_r != $past(cfg_r) |-> $past(commit) || $past(ext_reset_evt) || $past(rst))
      else $error("retention changed outside key sequence");

   a_abort_keeps_cfg:
   assert property (abort && !ext_reset_evt |=> cfg_r == $past(cfg_r))
      else $error("aborted sequence changed retention");

   a_ext_cfg_clear:
   assert property (ext_reset_evt |=> cfg_r == RCR_CFG_RST)
      else $error("external reset kept retention");

   a_rdata_idle:
   assert property (!$past(rd) |-> rdata == 32'h0000_0000)
      else $error("read data stood outside its cycle");

   a_irq_level:
   assert property (|(stat_r & mask_r) && !rd_stat && !wr_mask |=> irq)
      else $error("unmasked status did not raise interrupt");

   c_sw_reset:   cover property (sw_force ##1 sw_reset_req ##1 warm_rst == 1'b0);
   c_cfg_commit: cover property (key1_ok ##[1:4] wr_cfg ##[1:4] key2_ok ##1 cfg_r != 8'h00);
   c_cfg_abort:  cover property (key_r == RCR_KEY_HELD && abort);
   c_remap_sram: cover property (wr_map && wdata[0] ##1 sram_at_zero ##[1:20] wdt_reset_evt);
   c_ext_reset:  cover property (ext_reset_evt ##1 gpio_restore && dac_restore);

endmodule : rcr_reset_remap_ctrl
`default_nettype wire

//--- test_rcr_reset_remap_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_rcr_reset_remap_ctrl;
   import rcr_pkg::*;

   logic        clk;
   logic        rst;
   logic [31:0] addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic        ext_reset_evt;
   logic        wdt_reset_evt;
   logic        sw_reset_req;
   logic        boot_strap_pin;
   logic        flash_small;
   logic        sram_small;
   logic        sram_at_zero;
   logic        debug_port_en;
   logic        gpio_retain;
   logic        dac_retain;
   logic        gpio_restore;
   logic        dac_restore;
   logic        irq;
   int          n_fail;
   int          checked;
   logic [31:0] rv;

   rcr_reset_remap_ctrl dut_u (
      .clk           (clk),
      .rst           (rst),
      .addr          (addr),
      .wdata         (wdata),
      .wr            (wr),
      .rd            (rd),
      .rdata         (rdata),
      .ext_reset_evt (ext_reset_evt),
      .wdt_reset_evt (wdt_reset_evt),
      .sw_reset_req  (sw_reset_req),
      .boot_strap_pin(boot_strap_pin),
      .flash_small   (flash_small),
      .sram_small    (sram_small),
      .sram_at_zero  (sram_at_zero),
      .debug_port_en (debug_port_en),
      .gpio_retain   (gpio_retain),
      .dac_retain    (dac_retain),
      .gpio_restore  (gpio_restore),
      .dac_restore   (dac_restore),
      .irq           (irq)
   );

   // free running core clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // one place decides the verdict
   task automatic print_verdict();
      if (n_fail == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // one-cycle write strobe, effect visible right after the taking edge
   task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr    <= 1'b0;
      #1;
   endtask : wr_reg

   // read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg

   task automatic pulse_evt(input bit is_wdt);
      @(posedge clk);
      if (is_wdt) wdt_reset_evt <= 1'b1;
      else ext_reset_evt <= 1'b1;
      @(posedge clk);
      wdt_reset_evt <= 1'b0;
      ext_reset_evt <= 1'b0;
      #1;
   endtask : pulse_evt

   // power-on values, strap low leaves the debug port on the shared pins
   task automatic t_power_on();
      rd_reg(RCR_ADDR_CAUSE, rv);
      check(rv, 32'h00000001);
      rd_reg(RCR_ADDR_MAP_CTRL, rv);
      check(rv, 32'h00000010);
      check({31'h0, debug_port_en}, 32'h00000001);
      rd_reg(RCR_ADDR_RET_CFG, rv);
      check(rv, 32'h00000000);
      rd_reg(32'hFFFF0300, rv);
      check(rv, 32'h00000000);
      check({31'h0, sram_at_zero}, 32'h00000000);
   endtask : t_power_on

   // read-only map bits ignore writes; watchdog drops the remap
   task automatic t_remap_wdt();
      wr_reg(RCR_ADDR_MAP_CTRL, 32'h000000FF);
      check({31'h0, sram_at_zero}, 32'h00000001);
      rd_reg(RCR_ADDR_MAP_CTRL, rv);
      check(rv, 32'h00000011);
      pulse_evt(1'b1);
      check({31'h0, sram_at_zero}, 32'h00000000);
      check({30'h0, gpio_restore, dac_restore}, 32'h00000003);
      rd_reg(RCR_ADDR_CAUSE, rv);
      check(rv, 32'h00000003);
   endtask : t_remap_wdt

   // config only moves on key one, value, key two with no other write between but a repeated key one before the value
   task automatic t_key_seq();
      wr_reg(RCR_ADDR_RET_CFG, 32'h00000005);
      wr_reg(RCR_ADDR_KEY_SECOND, 32'h000000B1);
      rd_reg(RCR_ADDR_RET_CFG, rv);
      check(rv, 32'h00000000);
      wr_reg(RCR_ADDR_KEY_FIRST, 32'h00000076);
      wr_reg(RCR_ADDR_RET_CFG, 32'h00000005);
      wr_reg(RCR_ADDR_KEY_SECOND, 32'h000000B1);
      @(posedge clk);
      #1;
      check({30'h0, dac_retain, gpio_retain}, 32'h00000003);
      rd_reg(RCR_ADDR_RET_CFG, rv);
      check(rv, 32'h00000005);
      wr_reg(RCR_ADDR_KEY_FIRST, 32'h00000076);
      wr_reg(RCR_ADDR_RET_CFG, 32'h00000000);
      wr_reg(RCR_ADDR_CAUSE_CLR, 32'h00000000);
      wr_reg(RCR_ADDR_KEY_SECOND, 32'h000000B1);
      rd_reg(RCR_ADDR_RET_CFG, rv);
      check(rv, 32'h00000005);
   endtask : t_key_seq

   // software reset with both retentions on, strap now high
   task automatic t_sw_reset();
      @(posedge clk);
      boot_strap_pin <= 1'b1;
      sram_small     <= 1'b1;
      wr_reg(RCR_ADDR_MAP_CTRL, 32'h00000001);
      wr_reg(RCR_ADDR_CAUSE, 32'h00000004);
      check({31'h0, sw_reset_req}, 32'h00000001);
      @(posedge clk);
      #1;
      check({31'h0, sw_reset_req}, 32'h00000000);
      check({30'h0, gpio_restore, dac_restore}, 32'h00000000);
      check({31'h0, sram_at_zero}, 32'h00000000);
      @(posedge clk);
      #1;
      check({31'h0, debug_port_en}, 32'h00000000);
      rd_reg(RCR_ADDR_MAP_CTRL, rv);
      check(rv, 32'h0000001C);
      rd_reg(RCR_ADDR_CAUSE, rv);
      check(rv, 32'h00000007);
   endtask : t_sw_reset

   // clears act per bit; flags all zero after an external reset
   task automatic t_clear_ext();
      wr_reg(RCR_ADDR_CAUSE_CLR, 32'h00000002);
      rd_reg(RCR_ADDR_CAUSE, rv);
      check(rv, 32'h00000005);
      wr_reg(RCR_ADDR_CAUSE_CLR, 32'h00000007);
      rd_reg(RCR_ADDR_CAUSE, rv);
      check(rv, 32'h00000000);
      pulse_evt(1'b0);
      check({31'h0, gpio_restore}, 32'h00000001);
      rd_reg(RCR_ADDR_CAUSE, rv);
      check(rv, 32'h00000000);
      rd_reg(RCR_ADDR_RET_CFG, rv);
      check(rv, 32'h00000000);
   endtask : t_clear_ext

   // only the watchdog event is unmasked; status read clears it
   task automatic t_irq();
      rd_reg(RCR_ADDR_IRQ_STAT, rv);
      wr_reg(RCR_ADDR_IRQ_MASK, 32'h00000002);
      rd_reg(RCR_ADDR_IRQ_MASK, rv);
      check(rv, 32'h00000002);
      pulse_evt(1'b0);
      repeat (2) @(posedge clk);
      #1;
      check({31'h0, irq}, 32'h00000000);
      pulse_evt(1'b1);
      repeat (2) @(posedge clk);
      #1;
      check({31'h0, irq}, 32'h00000001);
      rd_reg(RCR_ADDR_IRQ_STAT, rv);
      check(rv, 32'h00000006);
      repeat (2) @(posedge clk);
      #1;
      check({31'h0, irq}, 32'h00000000);
   endtask : t_irq

   // main sequence
   initial begin
      n_fail         = 0;
      checked        = 0;
      rst            = 1'b1;
      addr           = 32'h00000000;
      wdata          = 32'h00000000;
      wr             = 1'b0;
      rd             = 1'b0;
      ext_reset_evt  = 1'b0;
      wdt_reset_evt  = 1'b0;
      boot_strap_pin = 1'b0;
      flash_small    = 1'b1;
      sram_small     = 1'b0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_power_on();
      t_remap_wdt();
      t_key_seq();
      t_sw_reset();
      t_clear_ext();
      t_irq();
      print_verdict();
   end

   // the tests need about a hundred cycles; this cuts a hang short
   initial begin
      #50000;
      n_fail++;
      print_verdict();
   end
endmodule : test_rcr_reset_remap_ctrl
`default_nettype wire
